// ==== shared/cho_map.svh ====
`ifndef CHO_MAP_SVH
`define CHO_MAP_SVH

// Command codes
`define CHO_CMD_OPTIONS     8'h12
`define CHO_CMD_CHG_CURRENT 8'h14
`define CHO_CMD_CHG_VOLTAGE 8'h15

// Option word reset value and writable bits (bits 4:3 unused)
`define CHO_OPT_RESET       16'h7904
`define CHO_OPT_WMASK       16'hFFE7
`define CHO_BIT_LEARN       6
`define CHO_BIT_MON         5

// Watchdog selector codes
`define CHO_WD_OFF          2'h0
`define CHO_WD_SEL_44       2'h1
`define CHO_WD_SEL_88       2'h2

// Clock and times
`define CHO_CLK_HZ          125000000
`define CHO_DEG_SHORT_MS    150
`define CHO_DEG_LONG_MS     1300
`define CHO_WD_44_S         44
`define CHO_WD_88_S         88
`define CHO_WD_175_S        175

// Cycle counts derived from times and clock rate
`define CHO_DEG_SHORT_CYC   (64'(`CHO_DEG_SHORT_MS) * 64'(`CHO_CLK_HZ) / 64'd1000)
`define CHO_DEG_LONG_CYC    (64'(`CHO_DEG_LONG_MS) * 64'(`CHO_CLK_HZ) / 64'd1000)
`define CHO_WD_44_CYC       (64'(`CHO_WD_44_S) * 64'(`CHO_CLK_HZ))
`define CHO_WD_88_CYC       (64'(`CHO_WD_88_S) * 64'(`CHO_CLK_HZ))
`define CHO_WD_175_CYC      (64'(`CHO_WD_175_S) * 64'(`CHO_CLK_HZ))

`endif

// ==== shared/cho_pkg.sv ====
package cho_pkg;

    // Option word layout, bit 15 first
    typedef struct packed {
        logic       deglitch_long;
        logic [1:0] wd_sel;
        logic [1:0] depl_sel;
        logic       trim_up;
        logic       trim_en;
        logic [1:0] short_sel;
        logic       learn;
        logic       mon_sel;
        logic [1:0] unused;
        logic [1:0] oc_sel;
        logic       inhibit;
    } cho_opt_t;

    // One decoded word command from the bus framer
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  code;
        logic [15:0] data;
    } cho_cmd_t;

    // Settings driven to the analog side
    typedef struct packed {
        logic       trim_en;
        logic       trim_up;
        logic [1:0] short_sel;
        logic [1:0] depl_sel;
        logic       mon_sel;
        logic [1:0] oc_sel;
    } cho_ctl_t;

    // System power source selection
    typedef enum logic [1:0] {
        SRC_BATT,
        SRC_ADAPTER,
        SRC_LEARN
    } cho_src_t;

endpackage

// ==== logic/cho_timer.sv ====
`timescale 1ns/1ps
module cho_timer #(
    parameter int W = 36
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         run,
    input  wire logic         clr,
    input  wire logic [W-1:0] limit,
    output logic              done
);
    logic [W-1:0] cnt;
    wire          at_limit;

    // Reached the selected limit
    assign at_limit = (cnt >= limit);
    assign done     = at_limit;

    // Saturating count while running, clear wins
    always_ff @(posedge clk) begin
        if (!nrst || clr) begin
            cnt <= '0;
        end else if (run && !at_limit) begin
            cnt <= cnt + 1'b1;
        end
    end
endmodule

// ==== logic/cho_options.sv ====
// Overview of operation
// - Word write to options code updates fields; fields start at power-on defaults.
// - Option-changing commands accepted only with supply and adapter detect above limits.
// - Bit 15 picks adapter-present rising deglitch: 0 gives 150 ms, 1 gives 1.3 s.
// - Long deglitch only after adapter switch turned on then off once.
// - Bits 14:13 set watchdog: off, 44 s, 88 s, 175 s default.
// - Enabled watchdog suspends charging when no voltage or current write arrives in time.
// - Suspended charging resumes on next charge voltage or current write.
// - Bits 12:11 pick battery depletion threshold, 70.97 percent by default.
// - In learn, depletion turns battery switch off and adapter switch on.
// - Bit 9 enables frequency trim; bit 10 lowers or raises it 18 percent.
// - Bits 8:7 pick high-side short threshold, 700 mV by default.
// - Writing one to bit 6 starts learn: adapter switch off, battery switch on.
// - Learn bit clears itself when learn ends at the depletion threshold.
// - Writing zero to learn bit stops learn, battery off, adapter on; resets zero.
// - Bit 5 routes current monitor: 0 adapter amplifier, 1 charge amplifier.
// - Bits 2:1 set adapter overcurrent threshold: off, 1.33x, 1.66x default, 2.22x.
// - Bit 0 set inhibits charging; clear allows it, clear by default.
`timescale 1ns/1ps
`include "cho_map.svh"
module cho_options #(
    parameter logic [35:0] DEG_SHORT_CYC = 36'(`CHO_DEG_SHORT_CYC),
    parameter logic [35:0] DEG_LONG_CYC  = 36'(`CHO_DEG_LONG_CYC),
    parameter logic [35:0] WD_44_CYC     = 36'(`CHO_WD_44_CYC),
    parameter logic [35:0] WD_88_CYC     = 36'(`CHO_WD_88_CYC),
    parameter logic [35:0] WD_175_CYC    = 36'(`CHO_WD_175_CYC)
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire cho_pkg::cho_cmd_t cmd,
    input  wire logic             supply_above_lockout,
    input  wire logic             adapter_detect_above_min,
    input  wire logic             adapter_detect_input,
    input  wire logic             battery_depleted,
    output logic                  cmd_ack,
    output logic [15:0]           rdata,
    output logic                  adapter_present_flag,
    output logic                  adapter_switch_transistor,
    output logic                  battery_switch_transistor,
    output logic                  charge_enable,
    output logic                  charge_suspended,
    output cho_pkg::cho_ctl_t     analog_ctl
);
    cho_pkg::cho_opt_t opt;
    cho_pkg::cho_opt_t next_opt;
    cho_pkg::cho_src_t src;
    cho_pkg::cho_src_t next_src;
    cho_pkg::cho_ctl_t next_ctl;
    logic              switch_cycled;
    logic              suspended;
    logic [35:0]       hi_run;
    wire               link_ok;
    wire               opt_wr;
    wire               opt_rd;
    wire               vi_wr;
    wire               learn_done;
    wire               deg_long_sel;
    wire  [35:0]       deg_limit;
    wire  [35:0]       wd_limit;
    wire               wd_enabled;
    wire               wd_run;
    wire               wd_done;
    wire               wd_expire;
    wire               deg_done;
    wire  [15:0]       wr_word;

    // Bus commands only count with supply and adapter detect high enough
    assign link_ok = supply_above_lockout && adapter_detect_above_min;
    assign opt_wr  = cmd.wr && link_ok && (cmd.code == `CHO_CMD_OPTIONS);
    assign opt_rd  = cmd.rd && link_ok && (cmd.code == `CHO_CMD_OPTIONS);
    assign vi_wr   = cmd.wr && link_ok && ((cmd.code == `CHO_CMD_CHG_CURRENT) ||
                                           (cmd.code == `CHO_CMD_CHG_VOLTAGE));

    // Written word with unused bits kept from the current option word
    assign wr_word = (cmd.data & `CHO_OPT_WMASK) | (16'(opt) & ~`CHO_OPT_WMASK);

    // Learn ends when battery reaches the depletion threshold
    assign learn_done = (src == cho_pkg::SRC_LEARN) && battery_depleted;

    // Next option word; a host write wins over the self clear
    always_comb begin
        next_opt = opt;
        if (learn_done) begin
            next_opt.learn = 1'b0;
        end
        if (opt_wr) begin
            next_opt = cho_pkg::cho_opt_t'(wr_word);
        end
    end

    // Option register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            opt <= cho_pkg::cho_opt_t'(`CHO_OPT_RESET);
        end else begin
            opt <= next_opt;
        end
    end

    // Deglitch length: long only once the adapter switch has cycled
    assign deg_long_sel = opt.deglitch_long && switch_cycled;
    assign deg_limit    = deg_long_sel ? DEG_LONG_CYC : DEG_SHORT_CYC;

    cho_timer #(
        .W     (36)
    ) u_deglitch (
        .clk   (clk),
        .nrst  (nrst),
        .run   (adapter_detect_input),
        .clr   (!adapter_detect_input),
        .limit (deg_limit),
        .done  (deg_done)
    );

    // Adapter present: delayed rise, immediate fall
    always_ff @(posedge clk) begin
        if (!nrst || !adapter_detect_input) begin
            adapter_present_flag <= 1'b0;
        end else if (deg_done) begin
            adapter_present_flag <= 1'b1;
        end
    end

    // Remember one on-then-off pass of the adapter switch
    always_ff @(posedge clk) begin
        if (!nrst) begin
            switch_cycled <= 1'b0;
        end else if (adapter_switch_transistor && (next_src != cho_pkg::SRC_ADAPTER)) begin
            switch_cycled <= 1'b1;
        end
    end

    // Source choice from adapter presence and learn bit
    always_comb begin
        case (src)
            cho_pkg::SRC_BATT,
            cho_pkg::SRC_ADAPTER,
            cho_pkg::SRC_LEARN: begin
                if (!adapter_present_flag) begin
                    next_src = cho_pkg::SRC_BATT;
                end else if (next_opt.learn) begin
                    next_src = cho_pkg::SRC_LEARN;
                end else begin
                    next_src = cho_pkg::SRC_ADAPTER;
                end
            end
            default: begin
                next_src = cho_pkg::SRC_BATT;
            end
        endcase
    end

    // Source state and switch drives
    always_ff @(posedge clk) begin
        if (!nrst) begin
            src                       <= cho_pkg::SRC_BATT;
            adapter_switch_transistor <= 1'b0;
            battery_switch_transistor <= 1'b1;
        end else begin
            src                       <= next_src;
            adapter_switch_transistor <= (next_src == cho_pkg::SRC_ADAPTER);
            battery_switch_transistor <= (next_src != cho_pkg::SRC_ADAPTER);
        end
    end

    // Watchdog period selection
    assign wd_enabled = (opt.wd_sel != `CHO_WD_OFF);
    assign wd_limit   = (opt.wd_sel == `CHO_WD_SEL_44) ? WD_44_CYC :
                        (opt.wd_sel == `CHO_WD_SEL_88) ? WD_88_CYC : WD_175_CYC;
    assign wd_run     = wd_enabled && !suspended;
    assign wd_expire  = wd_run && wd_done;

    cho_timer #(
        .W     (36)
    ) u_watchdog (
        .clk   (clk),
        .nrst  (nrst),
        .run   (wd_run),
        .clr   (vi_wr || !wd_enabled),
        .limit (wd_limit),
        .done  (wd_done)
    );

    // Suspend on expiry, resume on next voltage or current write
    always_ff @(posedge clk) begin
        if (!nrst || !wd_enabled) begin
            suspended <= 1'b0;
        end else if (wd_expire) begin
            suspended <= 1'b1;
        end else if (vi_wr) begin
            suspended <= 1'b0;
        end
    end

    // Analog settings from the option word, trim_up gated by trim_en
    assign next_ctl.trim_en   = next_opt.trim_en;
    assign next_ctl.trim_up   = next_opt.trim_en && next_opt.trim_up;
    assign next_ctl.short_sel = next_opt.short_sel;
    assign next_ctl.depl_sel  = next_opt.depl_sel;
    assign next_ctl.mon_sel   = next_opt.mon_sel;
    assign next_ctl.oc_sel    = next_opt.oc_sel;

    // Registered outputs to the power stage
    always_ff @(posedge clk) begin
        if (!nrst) begin
            analog_ctl       <= '0;
            charge_enable    <= 1'b0;
            charge_suspended <= 1'b0;
        end else begin
            analog_ctl       <= next_ctl;
            charge_enable    <= !opt.inhibit && !suspended;
            charge_suspended <= suspended;
        end
    end

    // Read data and acknowledge
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata   <= 16'h0000;
            cmd_ack <= 1'b0;
        end else begin
            rdata   <= opt_rd ? 16'(opt) : 16'h0000;
            cmd_ack <= opt_rd || opt_wr || vi_wr;
        end
    end

    // Checker helper: consecutive cycles with adapter detect high
    always_ff @(posedge clk) begin
        if (!nrst || !adapter_detect_input) begin
            hi_run <= 36'h000000000;
        end else if (hi_run != 36'hFFFFFFFFF) begin
            hi_run <= hi_run + 36'h000000001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_reset_default: assert property (
        $rose(nrst) |-> (16'(opt) == `CHO_OPT_RESET) && !opt.learn && !opt.inhibit)
        else $error("options not at power-on default after reset");
    chk_write_update: assert property (
        opt_wr |=> (16'(opt) == ($past(cmd.data) & `CHO_OPT_WMASK)))
        else $error("accepted options write not stored");
    chk_write_gated: assert property (
        (cmd.wr && !link_ok && !learn_done) |=> $stable(opt))
        else $error("options changed while bus communication disabled");
    chk_deglitch_len: assert property (
        $rose(adapter_present_flag) |-> ($past(hi_run) >= $past(deg_limit)))
        else $error("adapter present rose before deglitch time");
    chk_first_short: assert property (
        (!switch_cycled && $rose(adapter_present_flag)) |-> ($past(hi_run) == DEG_SHORT_CYC))
        else $error("long deglitch used before switch cycled");
    chk_wd_disabled: assert property (
        (opt.wd_sel == `CHO_WD_OFF) |=> !suspended)
        else $error("charging suspended with watchdog disabled");
    chk_wd_suspend: assert property (
        wd_expire |=> suspended ##1 !charge_enable)
        else $error("watchdog expiry did not suspend charging");
    chk_wd_resume: assert property (
        (suspended && vi_wr && wd_enabled) |=> !suspended)
        else $error("charge write did not resume charging");
    chk_trim_gate: assert property (
        analog_ctl.trim_up |-> analog_ctl.trim_en)
        else $error("frequency raise without trim enable");
    chk_learn_switch: assert property (
        (src == cho_pkg::SRC_LEARN) |-> battery_switch_transistor && !adapter_switch_transistor)
        else $error("learn cycle with wrong switch states");
    chk_learn_done: assert property (
        (learn_done && !opt_wr) |=> !opt.learn ##1 adapter_switch_transistor)
        else $error("learn bit not self cleared at depletion");
    chk_learn_stop: assert property (
        (opt_wr && !cmd.data[`CHO_BIT_LEARN] && adapter_present_flag)
            |=> adapter_switch_transistor && !battery_switch_transistor)
        else $error("learn stop did not restore adapter switch");
    chk_mon_route: assert property (
        opt_wr |=> (analog_ctl.mon_sel == $past(cmd.data[`CHO_BIT_MON])))
        else $error("current monitor routing does not follow option");
    chk_inhibit: assert property (
        opt.inhibit |=> !charge_enable)
        else $error("charging enabled while inhibited");

    cov_learn_end: cover property (learn_done ##1 !opt.learn);
    cov_wd_cycle: cover property (wd_expire ##[1:20] (suspended && vi_wr));
    cov_long_deglitch: cover property (deg_long_sel && $rose(adapter_present_flag));
endmodule

// ==== tb/cho_host_model.sv ====
`timescale 1ns/1ps
module cho_host_model (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire cho_pkg::cho_cmd_t req,
    input  wire logic              keep_en,
    input  wire logic [15:0]       keep_gap,
    output cho_pkg::cho_cmd_t      cmd
);
    logic [15:0] gap_cnt;

    // Bench request first, else periodic charge current refresh
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cmd     <= '0;
            gap_cnt <= '0;
        end else if (req.wr || req.rd) begin
            cmd <= req;
        end else if (keep_en && gap_cnt >= keep_gap) begin
            cmd     <= '{wr: 1'b1, rd: 1'b0, code: 8'h14, data: 16'h0100};
            gap_cnt <= '0;
        end else begin
            // Idle word lines flip so stale data never looks valid
            cmd     <= '{wr: 1'b0, rd: 1'b0, code: ~cmd.code, data: ~cmd.data};
            gap_cnt <= gap_cnt + 16'h1;
        end
    end
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`include "cho_map.svh"
module testbench;
    logic              clk;
    logic              nrst;
    cho_pkg::cho_cmd_t req;
    cho_pkg::cho_cmd_t cmd;
    cho_pkg::cho_ctl_t actl;
    logic              sup_ok, det_ok, det_in, depl, keep_en;
    logic              cmd_ack, flag, asw, bsw, chg_en, susp;
    logic [15:0]       rdata;
    logic [15:0]       opt_m;
    logic [15:0]       gap;
    int                err_total, compares, cyc;

    cho_host_model u_host (.clk(clk), .nrst(nrst), .req(req), .keep_en(keep_en),
        .keep_gap(gap), .cmd(cmd));

    cho_options #(.DEG_SHORT_CYC(36'd20), .DEG_LONG_CYC(36'd60), .WD_44_CYC(36'd100),
        .WD_88_CYC(36'd200), .WD_175_CYC(36'd400)) u_dut (
        .clk(clk), .nrst(nrst), .cmd(cmd), .supply_above_lockout(sup_ok),
        .adapter_detect_above_min(det_ok), .adapter_detect_input(det_in),
        .battery_depleted(depl), .cmd_ack(cmd_ack), .rdata(rdata),
        .adapter_present_flag(flag), .adapter_switch_transistor(asw),
        .battery_switch_transistor(bsw), .charge_enable(chg_en),
        .charge_suspended(susp), .analog_ctl(actl));

    // Clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end

    function automatic logic [15:0] ctl_of(logic [15:0] o);
        return {7'h00, o[9], o[10] & o[9], o[8:7], o[12:11], o[5], o[2:1]};
    endfunction

    task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
        compares++;
        if (exp !== got) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic step(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // One command through the host, answer looked for in a bounded window
    task automatic send(logic w, logic [7:0] code, logic [15:0] d,
                        output logic ack, output logic [15:0] rd);
        @(posedge clk);
        req <= '{wr: w, rd: !w, code: code, data: d};
        @(posedge clk);
        req <= '0;
        ack = 1'b0;
        rd = 16'h0;
        for (int i = 0; i < 4; i++) begin
            step(1);
            if (cmd_ack === 1'b1) begin
                ack = 1'b1;
                rd = rdata;
                break;
            end
        end
    endtask

    task automatic wr_chk(logic [7:0] code, logic [15:0] d, logic exp_ack);
        logic        a;
        logic [15:0] r;
        send(1'b1, code, d, a, r);
        chk("write_ack", exp_ack, a);
        if (a && code == `CHO_CMD_OPTIONS) opt_m = d & `CHO_OPT_WMASK;
    endtask

    task automatic rd_chk(logic exp_ack);
        logic        a;
        logic [15:0] r;
        send(1'b0, `CHO_CMD_OPTIONS, 16'h0, a, r);
        chk("read_ack", exp_ack, a);
        if (exp_ack) chk("options", opt_m, r);
    endtask

    // Count cycles from detect rising to flag rising
    task automatic rise(int lim);
        int n;
        n = 0;
        @(posedge clk) det_in <= 1'b1;
        while (flag !== 1'b1 && n < 200) begin
            step(1);
            n++;
        end
        chk("deglitch", 1'b1, n >= lim && n <= lim + 2);
    endtask

    // Starve the watchdog and time the suspension
    task automatic starve(int lim);
        int n;
        n = 0;
        wr_chk(`CHO_CMD_CHG_CURRENT, 16'h0100, 1'b1);
        while (susp !== 1'b1 && n < lim + 20) begin
            step(1);
            n++;
        end
        chk("wd_time", 1'b1, n >= lim - 2 && n <= lim + 4);
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        logic [15:0] d;
        int          hits;
        int          lim;
        nrst = 1'b0;
        req = '0;
        {sup_ok, det_ok, det_in, depl, keep_en} = 5'b11000;
        err_total = 0;
        compares = 0;
        cyc = 0;
        gap = 16'h0028;
        opt_m = `CHO_OPT_RESET;
        void'($urandom(32'h46a47896));
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        step(2);
        chk("ctl", ctl_of(opt_m), actl);
        chk("chg_en", 1'b1, chg_en);
        chk("batt_sw", 1'b1, bsw);
        rd_chk(1'b1);
        // Random option words, learn bit held clear
        for (int k = 0; k < 10; k++) begin
            wr_chk(`CHO_CMD_CHG_CURRENT, 16'h0100, 1'b1);
            d = 16'($urandom) & 16'hFFBF;
            wr_chk(`CHO_CMD_OPTIONS, d, 1'b1);
            rd_chk(1'b1);
            chk("ctl", ctl_of(opt_m), actl);
            chk("chg_en", !opt_m[0], chg_en);
        end
        // Level inputs low or foreign code: no answer, no change
        @(posedge clk) sup_ok <= 1'b0;
        wr_chk(`CHO_CMD_OPTIONS, 16'h0001, 1'b0);
        rd_chk(1'b0);
        @(posedge clk) {sup_ok, det_ok} <= 2'b10;
        wr_chk(`CHO_CMD_OPTIONS, 16'h0001, 1'b0);
        @(posedge clk) det_ok <= 1'b1;
        wr_chk(8'h3F, 16'h0001, 1'b0);
        rd_chk(1'b1);
        // Each watchdog period: refreshed, then starved, then resumed
        for (int s = 1; s < 4; s++) begin
            lim = (s == 1) ? 100 : (s == 2) ? 200 : 400;
            wr_chk(`CHO_CMD_OPTIONS, 16'(s << 13), 1'b1);
            @(posedge clk) begin
                keep_en <= 1'b1;
                gap     <= 16'(16 + $urandom_range(24));
            end
            hits = 0;
            repeat (2 * lim) begin
                step(1);
                hits += int'(susp === 1'b1);
            end
            chk("refreshed", 16'h0, 16'(hits));
            @(posedge clk) keep_en <= 1'b0;
            step(4);
            starve(lim);
            chk("chg_en", 1'b0, chg_en);
            wr_chk(`CHO_CMD_CHG_VOLTAGE, 16'h1000, 1'b1);
            step(3);
            chk("resumed", 2'b01, {susp, chg_en});
        end
        wr_chk(`CHO_CMD_OPTIONS, 16'h0000, 1'b1);
        hits = 0;
        repeat (500) begin
            step(1);
            hits += int'(susp === 1'b1);
        end
        chk("wd_off", 16'h0, 16'(hits));
        // Deglitch: short pulse ignored, first insertion short, then long
        wr_chk(`CHO_CMD_OPTIONS, 16'h8000, 1'b1);
        @(posedge clk) det_in <= 1'b1;
        step(1 + $urandom_range(14));
        @(posedge clk) det_in <= 1'b0;
        step(30);
        chk("flag", 1'b0, flag);
        rise(20);
        step(2);
        chk("switches", 2'b10, {asw, bsw});
        @(posedge clk) det_in <= 1'b0;
        step(3);
        chk("flag_low", 2'b00, {flag, asw});
        rise(60);
        wr_chk(`CHO_CMD_OPTIONS, 16'h0000, 1'b1);
        @(posedge clk) det_in <= 1'b0;
        step(3);
        rise(20);
        step(2);
        // Learn cycle: start, stop, restart, end at depletion
        wr_chk(`CHO_CMD_OPTIONS, 16'h0040, 1'b1);
        step(2);
        chk("learn_on", 2'b01, {asw, bsw});
        wr_chk(`CHO_CMD_OPTIONS, 16'h0000, 1'b1);
        step(2);
        chk("learn_stop", 2'b10, {asw, bsw});
        wr_chk(`CHO_CMD_OPTIONS, 16'h0040, 1'b1);
        @(posedge clk) depl <= 1'b1;
        step(4);
        chk("learn_end", 2'b10, {asw, bsw});
        opt_m[`CHO_BIT_LEARN] = 1'b0;
        rd_chk(1'b1);
        summarize();
    end
endmodule
